// ---- src/tx_rx_list_status_logic.sv ----
// Descriptor-list command, transmit status and receive request logic
`default_nettype none
module tx_rx_list_status_logic (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        td_valid,
  input  wire logic [31:0] td_addr,
  input  wire logic        td_start,
  input  wire logic        td_end,
  input  wire logic        td_link_odd,
  input  wire logic [15:0] td_frame_size,
  input  wire logic [15:0] td_seg_sum,
  input  wire logic        td_zero_size,
  input  wire logic [4:0]  td_route_len,
  input  wire logic        td_prio_ok,
  input  wire logic        td_mgmt,
  input  wire logic [3:0]  td_src_class,
  input  wire logic [3:0]  td_attn,
  input  wire logic        td_fc_bit0,
  input  wire logic        tx_sent,
  input  wire logic        tx_sent_int,
  input  wire logic [31:0] tx_sent_addr,
  input  wire logic        tx_chain_done,
  output logic             tx_go,
  output logic             tx_stop,
  output logic [31:0]      tx_list_addr,
  output logic             tx_status_irq,
  output logic             cmd_status_irq,
  output logic             rx_go,
  output logic [31:0]      rx_list_addr,
  input  wire logic [15:0] rx_req_word,
  output logic             rx_desc_ready,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_ext_match,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_end_wait,
  input  wire logic        rx_link_odd,
  input  wire logic        rx_continue,
  output logic             rx_wb,
  output logic             rx_status_irq,
  output logic             rx_fcs_pass,
  output logic [4:0]       rx_route_pad_len
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [1:0]  ctrl;
  logic [23:0] bufcfg;
  logic [15:0] host_block_cmd_word;
  logic [15:0] host_block_arg0;
  logic [15:0] host_block_arg1;
  logic [15:0] adapter_block_cmd_word;
  logic [15:0] adapter_block_arg0;
  logic [15:0] adapter_block_arg1;
  logic [15:0] adapter_block_arg2;
  logic        tx_active;
  logic        sent_any;
  logic        expect_start;
  logic        fd_pend;
  logic        cc_pend;
  logic        err_pend;
  logic        halt_pend;
  logic [15:0] err_word;
  logic [31:0] err_ptr;
  logic [31:0] last_ptr;
  logic [31:0] frame_ptr;
  logic        rx_active;
  logic        rx_suspended;
  logic        wb_hold;
  logic        rx_int_req;
  logic        rx_wait_req;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  dp_addr;
  logic [15:0] cause;
  tx_rx_list_pkg::post_state_t state;
  logic [15:0] tx_outcome_word;

  // ****************************************
  // Bus slave
  // ****************************************
  // Zero wait states: every access completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
    end else if (ce && hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_comb begin
    hrdata = 32'h00000000;
    if (!rd_pend) begin
      hrdata = 32'h00000000;
    end else if (dp_addr == tx_rx_list_pkg::OFF_CTRL) begin
      hrdata = {30'h00000000, ctrl};
    end else if (dp_addr == tx_rx_list_pkg::OFF_BUFCFG) begin
      hrdata = {8'h00, bufcfg};
    end else if (dp_addr == tx_rx_list_pkg::OFF_HCMD) begin
      hrdata = {16'h0000, host_block_cmd_word};
    end else if (dp_addr == tx_rx_list_pkg::OFF_HARG0) begin
      hrdata = {16'h0000, host_block_arg0};
    end else if (dp_addr == tx_rx_list_pkg::OFF_HARG1) begin
      hrdata = {16'h0000, host_block_arg1};
    end else if (dp_addr == tx_rx_list_pkg::OFF_ACMD) begin
      hrdata = {16'h0000, adapter_block_cmd_word};
    end else if (dp_addr == tx_rx_list_pkg::OFF_AARG0) begin
      hrdata = {16'h0000, adapter_block_arg0};
    end else if (dp_addr == tx_rx_list_pkg::OFF_AARG1) begin
      hrdata = {16'h0000, adapter_block_arg1};
    end else if (dp_addr == tx_rx_list_pkg::OFF_AARG2) begin
      hrdata = {16'h0000, adapter_block_arg2};
    end else if (dp_addr == tx_rx_list_pkg::OFF_STATE) begin
      hrdata = {29'h00000000, rx_suspended, rx_active, tx_active};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl   <= 2'h0;
      bufcfg <= 24'h000000;
    end else if (ce && wr_pend && dp_addr == tx_rx_list_pkg::OFF_CTRL) begin
      ctrl <= hwdata[1:0];
    end else if (ce && wr_pend && dp_addr == tx_rx_list_pkg::OFF_BUFCFG) begin
      bufcfg <= hwdata[23:0];
    end
  end

  // ****************************************
  // Transmit descriptor checks
  // ****************************************
  always_comb begin
    cause = 16'h0000;
    if (td_start) begin
      cause[tx_rx_list_pkg::TXS_SIZE] = (td_frame_size != td_seg_sum) || td_zero_size ||
        (td_frame_size < tx_rx_list_pkg::MIN_HDR_BYTES + {11'h000, td_route_len});
      cause[tx_rx_list_pkg::TXS_THRESH] = 24'(td_frame_size) >
        24'((24'(bufcfg[15:0] - tx_rx_list_pkg::BUF_OVERHEAD)) * {16'h0000, bufcfg[23:16]});
      cause[tx_rx_list_pkg::TXS_PRIO] = !td_prio_ok;
      cause[tx_rx_list_pkg::TXS_MGMT] = td_mgmt && (td_src_class == 4'h0 || td_attn > 4'h1);
      cause[tx_rx_list_pkg::TXS_BAD_FC] = td_fc_bit0;
    end else begin
      cause[tx_rx_list_pkg::TXS_SIZE] = td_zero_size;
    end
    cause[tx_rx_list_pkg::TXS_ODD] = td_link_odd && !td_end;
    cause[tx_rx_list_pkg::TXS_FRAMING] = td_start != expect_start;
    if (cause != 16'h0000) begin
      cause[tx_rx_list_pkg::TXS_LIST_ERR] = 1'b1;
    end
  end

  // ****************************************
  // Commands and status posting
  // ****************************************
  assign tx_status_irq  = (state == tx_rx_list_pkg::S_TXI);
  assign cmd_status_irq = (state == tx_rx_list_pkg::S_CMDI);
  assign tx_outcome_word = adapter_block_arg0;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state                  <= tx_rx_list_pkg::S_IDLE;
      host_block_cmd_word    <= tx_rx_list_pkg::RST_WORD;
      host_block_arg0        <= tx_rx_list_pkg::RST_WORD;
      host_block_arg1        <= tx_rx_list_pkg::RST_WORD;
      adapter_block_cmd_word <= tx_rx_list_pkg::RST_WORD;
      adapter_block_arg0     <= tx_rx_list_pkg::RST_WORD;
      adapter_block_arg1     <= tx_rx_list_pkg::RST_WORD;
      adapter_block_arg2     <= tx_rx_list_pkg::RST_WORD;
      tx_active    <= 1'b0;
      sent_any     <= 1'b0;
      expect_start <= 1'b1;
      fd_pend      <= 1'b0;
      cc_pend      <= 1'b0;
      err_pend     <= 1'b0;
      halt_pend    <= 1'b0;
      err_word     <= 16'h0000;
      err_ptr      <= 32'h00000000;
      last_ptr     <= 32'h00000000;
      frame_ptr    <= 32'h00000000;
      tx_go        <= 1'b0;
      tx_stop      <= 1'b0;
      tx_list_addr <= 32'h00000000;
      rx_go        <= 1'b0;
      rx_list_addr <= 32'h00000000;
    end else if (ce) begin
      tx_go   <= 1'b0;
      tx_stop <= 1'b0;
      rx_go   <= 1'b0;
      case (state)
        tx_rx_list_pkg::S_IDLE: begin
          // words land with the interrupt state
          if (fd_pend) begin
            adapter_block_arg0 <= 16'h0002;
            {adapter_block_arg1, adapter_block_arg2} <= last_ptr;
            fd_pend <= 1'b0;
            state   <= tx_rx_list_pkg::S_TXI;
          end else if (cc_pend) begin
            adapter_block_arg0 <= 16'h0001;
            {adapter_block_arg1, adapter_block_arg2} <= sent_any ? last_ptr : 32'h00000000;
            cc_pend <= 1'b0;
            state   <= tx_rx_list_pkg::S_TXI;
          end else if (err_pend) begin
            adapter_block_arg0 <= err_word;
            {adapter_block_arg1, adapter_block_arg2} <= err_ptr;
            err_pend <= 1'b0;
            state    <= tx_rx_list_pkg::S_TXI;
          end else if (host_block_cmd_word != 16'h0000) begin
            host_block_cmd_word <= 16'h0000;
            if (host_block_cmd_word == tx_rx_list_pkg::CMD_SEND && !tx_active) begin
              tx_active    <= 1'b1;
              sent_any     <= 1'b0;
              expect_start <= 1'b1;
              tx_go        <= 1'b1;
              tx_list_addr <= {host_block_arg0, host_block_arg1};
            end else if (host_block_cmd_word == tx_rx_list_pkg::CMD_HALT && tx_active) begin
              tx_active <= 1'b0;
              tx_stop   <= 1'b1;
              cc_pend   <= 1'b1;
              halt_pend <= 1'b1;
            end else if (host_block_cmd_word == tx_rx_list_pkg::CMD_RECV) begin
              if (!ctrl[0] || rx_active || host_block_arg1[0]) begin
                adapter_block_cmd_word <= tx_rx_list_pkg::CMD_REJECT;
                adapter_block_arg0     <= tx_rx_list_pkg::CMD_RECV;
                state                  <= tx_rx_list_pkg::S_CMDI;
              end else begin
                rx_go        <= 1'b1;
                rx_list_addr <= {host_block_arg0, host_block_arg1};
              end
            end
          end
        end
        tx_rx_list_pkg::S_TXI: begin
          if (halt_pend && adapter_block_arg0[tx_rx_list_pkg::TXS_CMD_DONE]) begin
            adapter_block_cmd_word <= tx_rx_list_pkg::CMD_SEND;
            halt_pend <= 1'b0;
            state     <= tx_rx_list_pkg::S_CMDI;
          end else begin
            state <= tx_rx_list_pkg::S_IDLE;
          end
        end
        default: begin
          state <= tx_rx_list_pkg::S_IDLE;
        end
      endcase
      // Events come after the clears so that a set in the same cycle wins
      if (td_valid && tx_active) begin
        if (cause != 16'h0000) begin
          // end chain, point at frame start
          err_word  <= cause;
          // A missing start where one was expected marks this descriptor as the frame start
          err_ptr   <= (td_start || expect_start) ? td_addr : frame_ptr;
          err_pend  <= 1'b1;
          tx_active <= 1'b0;
          tx_stop   <= 1'b1;
        end else begin
          expect_start <= td_end;
          if (td_start) begin
            frame_ptr <= td_addr;
          end
        end
      end
      if (tx_sent) begin
        sent_any <= 1'b1;
        last_ptr <= tx_sent_addr;
        if (tx_sent_int) begin
          fd_pend <= 1'b1;
        end
      end
      if (tx_chain_done && tx_active) begin
        tx_active <= 1'b0;
        cc_pend   <= 1'b1;
      end
      if (wr_pend && dp_addr == tx_rx_list_pkg::OFF_HCMD) begin
        host_block_cmd_word <= hwdata[15:0];
      end
      if (wr_pend && dp_addr == tx_rx_list_pkg::OFF_HARG0) begin
        host_block_arg0 <= hwdata[15:0];
      end
      if (wr_pend && dp_addr == tx_rx_list_pkg::OFF_HARG1) begin
        host_block_arg1 <= hwdata[15:0];
      end
    end
  end

  // ****************************************
  // Receive side
  // ****************************************
  // valid bit gates descriptor use
  assign rx_desc_ready = rx_active && !rx_suspended && rx_req_word[tx_rx_list_pkg::RXQ_VALID];
  assign rx_route_pad_len = ctrl[1] ? tx_rx_list_pkg::PAD_ROUTE_LEN : 5'h00;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_active     <= 1'b0;
      rx_suspended  <= 1'b0;
      wb_hold       <= 1'b0;
      rx_int_req    <= 1'b0;
      rx_wait_req   <= 1'b0;
      rx_wb         <= 1'b0;
      rx_status_irq <= 1'b0;
      rx_fcs_pass   <= 1'b0;
    end else if (ce) begin
      rx_wb         <= 1'b0;
      rx_status_irq <= 1'b0;
      if (rx_go) begin
        rx_active    <= 1'b1;
        rx_suspended <= 1'b0;
      end
      if (rx_frame_start) begin
        rx_int_req  <= rx_req_word[tx_rx_list_pkg::RXQ_INT];
        rx_wait_req <= rx_req_word[tx_rx_list_pkg::RXQ_WAIT];
        rx_fcs_pass <= rx_req_word[tx_rx_list_pkg::RXQ_PASS_FCS] && rx_ext_match;
      end
      if (rx_continue) begin
        rx_suspended <= 1'b0;
        if (wb_hold) begin
          wb_hold <= 1'b0;
          rx_wb   <= 1'b1;
        end
      end
      if (rx_frame_done) begin
        if (rx_link_odd) begin
          wb_hold <= 1'b1;
        end else begin
          rx_wb <= 1'b1;
        end
        rx_status_irq <= rx_int_req || rx_wait_req || rx_end_wait;
        if (rx_wait_req || rx_end_wait) begin
          rx_suspended <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_done_excl;
    tx_status_irq |-> !(tx_outcome_word[0] && tx_outcome_word[1]);
  endproperty
  a_done_excl: assert property (p_done_excl) else $error("both done flags set");
  property p_reserved;
    tx_status_irq |-> tx_outcome_word[7:3] == 5'h00 && !tx_outcome_word[15];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_err_alone;
    tx_status_irq && tx_outcome_word[2] |-> tx_outcome_word[1:0] == 2'h0 && !fd_pend;
  endproperty
  a_err_alone: assert property (p_err_alone) else $error("error posted early");
  property p_words_first;
    tx_status_irq |=> $stable(adapter_block_arg0) && $stable(adapter_block_arg1);
  endproperty
  a_words_first: assert property (p_words_first) else $error("words not ready");
  property p_halt_cmd;
    ce && tx_status_irq && halt_pend && tx_outcome_word[0]
      |=> cmd_status_irq && adapter_block_cmd_word == 16'h0004;
  endproperty
  a_halt_cmd: assert property (p_halt_cmd) else $error("halt status wrong");
  property p_halt_ignore;
    ce && state == tx_rx_list_pkg::S_IDLE && !fd_pend && !cc_pend && !err_pend && !tx_active
      && host_block_cmd_word == 16'h0005 |=> !tx_stop && !halt_pend;
  endproperty
  a_halt_ignore: assert property (p_halt_ignore) else $error("idle halt acted");
  property p_rx_reject;
    ce && state == tx_rx_list_pkg::S_IDLE && !fd_pend && !cc_pend && !err_pend
      && host_block_cmd_word == 16'h0006 && host_block_arg1[0]
      |=> cmd_status_irq && adapter_block_cmd_word == 16'h0002 && !rx_go;
  endproperty
  a_rx_reject: assert property (p_rx_reject) else $error("misaligned not rejected");
  property p_rx_valid;
    rx_desc_ready |-> rx_req_word[0] && rx_active;
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("invalid descriptor used");
  property p_zero_size;
    ce && td_valid && tx_active && td_start && td_frame_size == 16'h0000
      |=> err_pend && err_word[8] && err_word[2] && !tx_active;
  endproperty
  a_zero_size: assert property (p_zero_size) else $error("zero size missed");
  property p_odd_hold;
    ce && rx_frame_done && rx_link_odd |=> !rx_wb && wb_hold;
  endproperty
  a_odd_hold: assert property (p_odd_hold) else $error("write-back not held");

  c_halt: cover property (cmd_status_irq && adapter_block_cmd_word == 16'h0004);
  c_reject: cover property (cmd_status_irq && adapter_block_cmd_word == 16'h0002);
  c_list_err: cover property (tx_status_irq && tx_outcome_word[2]);
  c_suspend: cover property (rx_suspended && rx_continue);
endmodule
`default_nettype wire

// ---- common/tx_rx_list_pkg.sv ----
// Constants for the descriptor-list status and command logic
// Function
// - Finishing or halting a send chain sets status bit 0; new command needed.
// - Command-done and frame-done never appear together in one status word.
// - Frame-done bit 1 after an interrupt-requesting frame; pointer names last frame.
// - Descriptor error sets bit 2, cause bits 8-14, ends chain, points frame start.
// - List error posts last, leaves descriptors untouched, carries no done flag.
// - Bit 8 for length mismatch, length below 15 plus routing, or zero length.
// - Bit 9 when length exceeds (buffer size minus 8) times buffer count.
// - Bit 10 for odd next link on a descriptor without end of frame.
// - Bit 11 for a start flag where unexpected, or missing where expected.
// - Bit 12 when the requested access priority is not allowed.
// - Bit 13 for management frame with source class zero or attention above one.
// - Bit 14 when frame control bit 0 is one.
// - Halt (0005) stops active chain, purges, posts status; idle halt is ignored.
// - Halt completion raises command interrupt with command word 0004 and pointer.
// - Receive command rejected when not open, already active, or misaligned.
// - With padding selected, routing field passed to host padded to 18 bytes.
// - State word written only at frame start/end; odd link waits for continue.
// - Descriptor used only once its valid bit 0 is set.
// - Request bit 4 on frame start interrupts the host after the frame.
// - Request bit 5 interrupts after the frame and suspends until continue.
// - Request bit 6 with external match passes the check sequence to the host.
// - Status words and pointer are written before the transmit interrupt.
`default_nettype none
package tx_rx_list_pkg;
  localparam logic [15:0] CMD_SEND   = 16'h0004;
  localparam logic [15:0] CMD_HALT   = 16'h0005;
  localparam logic [15:0] CMD_RECV   = 16'h0006;
  localparam logic [15:0] CMD_REJECT = 16'h0002;
  localparam int TXS_CMD_DONE = 0;
  localparam int TXS_FRM_DONE = 1;
  localparam int TXS_LIST_ERR = 2;
  localparam int TXS_SIZE     = 8;
  localparam int TXS_THRESH   = 9;
  localparam int TXS_ODD      = 10;
  localparam int TXS_FRAMING  = 11;
  localparam int TXS_PRIO     = 12;
  localparam int TXS_MGMT     = 13;
  localparam int TXS_BAD_FC   = 14;
  localparam int RXQ_VALID    = 0;
  localparam int RXQ_INT      = 4;
  localparam int RXQ_WAIT     = 5;
  localparam int RXQ_PASS_FCS = 6;
  localparam logic [15:0] MIN_HDR_BYTES = 16'h000F;
  localparam logic [15:0] BUF_OVERHEAD  = 16'h0008;
  localparam logic [4:0]  PAD_ROUTE_LEN = 5'h12;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BUFCFG = 8'h04;
  localparam logic [7:0] OFF_HCMD   = 8'h08;
  localparam logic [7:0] OFF_HARG0  = 8'h0C;
  localparam logic [7:0] OFF_HARG1  = 8'h10;
  localparam logic [7:0] OFF_ACMD   = 8'h14;
  localparam logic [7:0] OFF_AARG0  = 8'h18;
  localparam logic [7:0] OFF_AARG1  = 8'h1C;
  localparam logic [7:0] OFF_AARG2  = 8'h20;
  localparam logic [7:0] OFF_STATE  = 8'h24;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_TXI  = 3'b010,
    S_CMDI = 3'b100
  } post_state_t;
endpackage
`default_nettype wire

// ---- sim/tx_engine_model.sv ----
// Behavioural transmit engine standing beyond the status logic
`default_nettype none
module tx_engine_model (
  input  wire logic        clock,
  input  wire logic        stall,
  input  wire logic        tx_go,
  input  wire logic        tx_stop,
  input  wire logic [31:0] tx_list_addr,
  output logic             tx_sent,
  output logic             tx_sent_int,
  output logic [31:0]      tx_sent_addr,
  output logic             tx_chain_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    tx_sent = 1'b0;
    tx_sent_int = 1'b0;
    tx_sent_addr = 32'h0;
    tx_chain_done = 1'b0;
  end
  // One interrupting frame, then the chain runs dry; a stalled chain never sends
  always @(posedge clock) begin
    if (tx_go && !stall) cnt <= 1;
    else if (tx_stop || cnt == 40) cnt <= 0;
    else if (cnt != 0) cnt <= cnt + 1;
    tx_sent <= (cnt == 8);
    tx_sent_int <= (cnt == 8);
    // Pointer lines wander outside the report cycle
    tx_sent_addr <= (cnt == 8) ? tx_list_addr : ~tx_sent_addr;
    tx_chain_done <= (cnt == 40);
  end
endmodule
`default_nettype wire

// ---- sim/tb_tx_rx_list_status_logic.sv ----
// Self-checking bench for the descriptor-list status logic
`default_nettype none
module tb_tx_rx_list_status_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset_n = 0, ce = 1, hsel = 0, hwrite = 0, stall = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, td_addr = 0, q;
  logic td_valid = 0, td_start = 0, td_end = 0, td_link_odd = 0, td_zero_size = 0;
  logic td_prio_ok = 1, td_mgmt = 0, td_fc_bit0 = 0, rx_frame_start = 0, rx_ext_match = 0;
  logic rx_frame_done = 0, rx_end_wait = 0, rx_link_odd = 0, rx_continue = 0;
  logic [15:0] td_frame_size = 0, td_seg_sum = 0, rx_req_word = 0;
  logic [4:0] td_route_len = 0;
  logic [3:0] td_src_class = 4'h1, td_attn = 0;
  wire logic hready, hreadyout, hresp, tx_go, tx_stop, tx_status_irq, cmd_status_irq, rx_go;
  wire logic rx_desc_ready, rx_wb, rx_status_irq, rx_fcs_pass, tx_sent, tx_sent_int;
  wire logic tx_chain_done;
  wire logic [31:0] hrdata, tx_sent_addr, tx_list_addr, rx_list_addr;
  wire logic [4:0] rx_route_pad_len;
  wire logic [5:0] ev;
  int failures = 0, num_checks = 0, cycles = 0;
  localparam logic [15:0] ERR_WORD [8] = '{16'h0104, 16'h0204, 16'h0404, 16'h0804,
    16'h1004, 16'h2004, 16'h4004, 16'h0104};
  assign hready = hreadyout;
  assign ev = {tx_stop, rx_status_irq, rx_go, cmd_status_irq, tx_status_irq, tx_go};
  tx_rx_list_status_logic uut (.*);
  tx_engine_model partner (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ****************************************
  // Bus cycles: address phase, then data phase, each held until hready
  // ****************************************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Address goes high half first, then low half, then the code
  task automatic cmd(input logic [15:0] c, input logic [31:0] p);
    wr(tx_rx_list_pkg::OFF_HARG0, {16'h0, p[31:16]});
    wr(tx_rx_list_pkg::OFF_HARG1, {16'h0, p[15:0]});
    wr(tx_rx_list_pkg::OFF_HCMD, {16'h0, c});
  endtask
  // Pulses last one cycle, so they are looked for at every falling edge
  task automatic wait_ev(input int b, input logic want);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40 && !(seen && want); i++) begin
      @(negedge clock);
      if (ev[b] === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'(want));
  endtask
  task automatic t_send();
    stall <= 1'b0;
    cmd(tx_rx_list_pkg::CMD_SEND, 32'h0012_3400);
    wait_ev(0, 1'b1);
    chk(tx_list_addr, 32'h0012_3400);
    rd(tx_rx_list_pkg::OFF_HCMD, 32'h0);
    wait_ev(1, 1'b1);
    rd(tx_rx_list_pkg::OFF_AARG0, 32'h0002);
    rd(tx_rx_list_pkg::OFF_AARG2, 32'h3400);
    wait_ev(1, 1'b1);
    rd(tx_rx_list_pkg::OFF_AARG0, 32'h0001);
    rd(tx_rx_list_pkg::OFF_STATE, 32'h0);
  endtask
  task automatic t_halt();
    stall <= 1'b1;
    cmd(tx_rx_list_pkg::CMD_SEND, 32'h0012_3400);
    wait_ev(0, 1'b1);
    cmd(tx_rx_list_pkg::CMD_HALT, 32'h0);
    wait_ev(5, 1'b1);
    wait_ev(1, 1'b1);
    wait_ev(2, 1'b1);
    rd(tx_rx_list_pkg::OFF_ACMD, 32'h0004);
    rd(tx_rx_list_pkg::OFF_AARG0, 32'h0001);
    rd(tx_rx_list_pkg::OFF_AARG1, 32'h0);
    cmd(tx_rx_list_pkg::CMD_HALT, 32'h0);
    wait_ev(1, 1'b0);
  endtask
  task automatic t_errors();
    logic [15:0] sz;
    for (int k = 0; k < 8; k++) begin
      cmd(tx_rx_list_pkg::CMD_SEND, 32'h0000_1000);
      wait_ev(0, 1'b1);
      sz = (k == 0) ? 16'h0000 : (k == 1) ? 16'h03E1 : (k == 7) ? 16'h0010 : 16'h0014;
      @(posedge clock);
      td_valid <= 1'b1;
      td_start <= (k != 3);
      td_end <= (k != 2);
      td_link_odd <= (k == 2);
      td_zero_size <= (k == 0);
      td_prio_ok <= (k != 4);
      td_mgmt <= (k == 5);
      td_src_class <= (k == 5) ? 4'h0 : 4'h1;
      td_fc_bit0 <= (k == 6);
      td_route_len <= (k == 7) ? 5'h02 : 5'h00;
      td_frame_size <= sz;
      td_seg_sum <= sz;
      td_addr <= 32'h0005_2000 + 32'(k);
      @(posedge clock);
      td_valid <= 1'b0;
      wait_ev(1, 1'b1);
      rd(tx_rx_list_pkg::OFF_AARG0, {16'h0, ERR_WORD[k]});
      rd(tx_rx_list_pkg::OFF_AARG2, 32'h2000 + 32'(k));
    end
    rd(tx_rx_list_pkg::OFF_STATE, 32'h0);
  endtask
  task automatic t_rx();
    wr(tx_rx_list_pkg::OFF_CTRL, 32'h0);
    @(negedge clock) chk(32'(rx_route_pad_len), 32'h0);
    cmd(tx_rx_list_pkg::CMD_RECV, 32'h0000_8000);
    wait_ev(2, 1'b1);
    rd(tx_rx_list_pkg::OFF_ACMD, 32'h0002);
    wr(tx_rx_list_pkg::OFF_CTRL, 32'h3);
    @(negedge clock) chk(32'(rx_route_pad_len), 32'h12);
    cmd(tx_rx_list_pkg::CMD_RECV, 32'h0000_8001);
    wait_ev(2, 1'b1);
    cmd(tx_rx_list_pkg::CMD_RECV, 32'h0000_8000);
    wait_ev(3, 1'b1);
    chk(rx_list_addr, 32'h0000_8000);
    cmd(tx_rx_list_pkg::CMD_RECV, 32'h0000_8000);
    wait_ev(2, 1'b1);
    @(posedge clock) rx_req_word <= 16'h0010;
    @(negedge clock) chk(32'(rx_desc_ready), 32'h0);
    @(posedge clock) rx_req_word <= 16'h0011;
    @(negedge clock) chk(32'(rx_desc_ready), 32'h1);
    @(posedge clock) rx_frame_start <= 1'b1;
    @(posedge clock) rx_frame_start <= 1'b0;
    rx_frame_done <= 1'b1;
    @(posedge clock) rx_frame_done <= 1'b0;
    wait_ev(4, 1'b1);
    chk(32'(rx_fcs_pass), 32'h0);
    // Second frame: wait request, check sequence passed, odd link holds the write-back
    @(posedge clock) rx_req_word <= 16'h0061;
    rx_ext_match <= 1'b1;
    rx_frame_start <= 1'b1;
    @(posedge clock) rx_frame_start <= 1'b0;
    rx_frame_done <= 1'b1;
    rx_link_odd <= 1'b1;
    @(posedge clock) rx_frame_done <= 1'b0;
    rx_link_odd <= 1'b0;
    @(negedge clock) chk(32'(rx_fcs_pass), 32'h1);
    chk(32'(rx_wb), 32'h0);
    chk(32'(rx_status_irq), 32'h1);
    chk(32'(rx_desc_ready), 32'h0);
    rd(tx_rx_list_pkg::OFF_STATE, 32'h6);
    @(posedge clock) rx_continue <= 1'b1;
    @(posedge clock) rx_continue <= 1'b0;
    @(negedge clock) chk(32'(rx_wb), 32'h1);
    rd(tx_rx_list_pkg::OFF_STATE, 32'h2);
    rd(8'h40, 32'h0);
    wr(tx_rx_list_pkg::OFF_ACMD, 32'hFFFF);
    rd(tx_rx_list_pkg::OFF_ACMD, 32'h0002);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    wr(tx_rx_list_pkg::OFF_BUFCFG, 32'h0004_0100);
    t_send();
    t_halt();
    t_errors();
    t_rx();
    close_out();
  end
endmodule
`default_nettype wire
